// File: shared/gpio_pin_pkg.sv
// Constants, register map and types of the pin and sync/error pin controller.
// Assumes an APB slave with 32-bit data; registers sit at four times their index.
package gpio_pin_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned CFG_W = 16;

  // Register indices; byte address is four times the index.
  localparam logic [5:0] IDX_PIN_CONFIG = 6'h06;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h08;
  localparam logic [5:0] IDX_IRQ_CLEAR = 6'h09;
  localparam logic [5:0] IDX_IRQ_ENABLE = 6'h0a;
  localparam logic [5:0] IDX_AUX_CTRL = 6'h0b;

  // Pin configuration fields.
  localparam int unsigned BIT_EXT_MUX_DRIVE = 12;
  localparam int unsigned BIT_SYNC_EN = 11;
  localparam int unsigned BIT_ERR_MODE_HI = 10;
  localparam int unsigned BIT_ERR_MODE_LO = 9;
  localparam int unsigned BIT_ERR_PIN_LEVEL = 8;
  localparam int unsigned BIT_PIN_ONE_INPUT_EN = 5;
  localparam int unsigned BIT_PIN_ZERO_INPUT_EN = 4;
  localparam int unsigned BIT_PIN_ONE_OUTPUT_EN = 3;
  localparam int unsigned BIT_PIN_ZERO_OUTPUT_EN = 2;
  localparam int unsigned BIT_PIN_ONE_VALUE = 1;
  localparam int unsigned BIT_PIN_ZERO_VALUE = 0;
  localparam logic [15:0] PIN_CONFIG_RESET = 16'h0800;
  localparam logic [15:0] PIN_CONFIG_WMASK = 16'h1f3f;

  // Auxiliary control register fields.
  localparam int unsigned BIT_ALTERNATE_SYNC = 0;

  // Interrupt event bits, shared by status, clear and enable.
  localparam int unsigned EV_W = 3;
  localparam int unsigned EV_SYNC_LOW = 0;
  localparam int unsigned EV_ERR_IN = 1;
  localparam int unsigned EV_STALL = 2;

  localparam int unsigned MAX_AUTO_SEQ = 4;

  typedef enum logic [1:0] {
    ERR_OFF = 2'h0,
    ERR_INPUT = 2'h1,
    ERR_OPEN_DRAIN = 2'h2,
    ERR_GP_OUTPUT = 2'h3
  } err_mode_t;

  typedef enum logic [1:0] {
    ST_RUN = 2'h0,
    ST_STALL = 2'h1
  } sync_state_t;

endpackage

// File: src/pin_sync2.sv
// Two-flop synchroniser for asynchronous pin levels.
// Assumes the caller reads only the output; the first stage stays private.
`timescale 1ns/1ps
`default_nettype none

module pin_sync2 #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stage_reg <= RESET_VAL;
      sync_out <= RESET_VAL;
    end
    else
    begin
      stage_reg <= async_in;
      sync_out <= stage_reg;
    end
  end

endmodule
`default_nettype wire

// File: src/gpio_sync_error_pin_control.sv
// General-purpose pin and sync/error pin controller with APB registers.
// Assumes the channel sequencer and error sources run on pclk; pins are asynchronous.
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module gpio_sync_error_pin_control
  import gpio_pin_pkg::*;
#(
  parameter int unsigned ADDR_W = 8,
  parameter int unsigned ERR_SRC_W = 4,
  parameter int unsigned CHAN_CNT_W = 4
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Channel sequencer and error sources
  input wire logic [1:0] chan_slot,
  input wire logic chan_switch_due,
  input wire logic [CHAN_CNT_W-1:0] chan_enabled_count,
  input wire logic [ERR_SRC_W-1:0] err_sources,
  // Converter control
  output logic converter_hold,
  output logic conversion_stall,
  output logic adc_error,
  output logic [2:0] seq_channels,
  output logic irq,
  // General-purpose pins
  input wire logic gp_pin_zero_in,
  output logic gp_pin_zero_out,
  output logic gp_pin_zero_oe,
  input wire logic gp_pin_one_in,
  output logic gp_pin_one_out,
  output logic gp_pin_one_oe,
  // Sync/error pin
  input wire logic sync_err_in,
  output logic sync_err_out,
  output logic sync_err_oe
);

  if (ADDR_W < 8 || ERR_SRC_W < 1 || CHAN_CNT_W < 3)
  begin : g_param_check
    $error("gpio_sync_error_pin_control: parameter out of range");
  end

  function automatic logic [5:0] reg_index(input logic [ADDR_W-1:0] addr);
    reg_index = addr[7:2];
  endfunction

  function automatic logic reg_mapped(input logic [ADDR_W-1:0] addr);
    logic [5:0] idx;
    idx = reg_index(addr);
    // Only the low eight address bits decode; anything above them must be zero.
    reg_mapped = (addr[1:0] == 2'h0) && ((addr >> 8) == ADDR_W'(0)) &&
      (idx == IDX_PIN_CONFIG || idx == IDX_IRQ_STATUS || idx == IDX_IRQ_CLEAR ||
       idx == IDX_IRQ_ENABLE || idx == IDX_AUX_CTRL);
  endfunction

  logic [CFG_W-1:0] cfg_reg;
  logic alternate_sync_reg;
  logic [EV_W-1:0] irq_status_reg;
  logic [EV_W-1:0] irq_status_next;
  logic [EV_W-1:0] irq_enable_reg;
  logic [EV_W-1:0] irq_events;
  logic [EV_W-1:0] irq_clear;
  logic [2:0] pins_sync;
  logic sync_prev_reg;
  logic sync_level;
  sync_state_t sync_state_reg;
  sync_state_t sync_state_next;
  err_mode_t err_mode;
  logic setup_phase;
  logic write_access;
  logic alt_effective;
  logic sync_enabled;
  logic [CFG_W-1:0] cfg_readback;

  // Pins are sampled twice before anything looks at them; the sync pin idles high.
  pin_sync2 #(
    .WIDTH(3),
    .RESET_VAL(3'h4)
  ) u_pin_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({sync_err_in, gp_pin_one_in, gp_pin_zero_in}),
    .sync_out(pins_sync)
  );

  assign sync_level = pins_sync[2];
  assign err_mode = err_mode_t'(cfg_reg[BIT_ERR_MODE_HI:BIT_ERR_MODE_LO]);
  assign sync_enabled = cfg_reg[BIT_SYNC_EN];
  assign alt_effective = alternate_sync_reg && (chan_enabled_count > CHAN_CNT_W'(1));
  assign setup_phase = psel && !penable;
  assign write_access = psel && penable && pready && pwrite && !pslverr;

  // APB: data is prepared in the setup cycle, so every access takes one wait-free cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= setup_phase;
      pslverr <= setup_phase && !reg_mapped(paddr);
    end
  end

  // Input-enabled bits read the pin, otherwise the stored value.
  always_comb
  begin
    cfg_readback = cfg_reg;
    if (cfg_reg[BIT_PIN_ONE_INPUT_EN])
    begin
      cfg_readback[BIT_PIN_ONE_VALUE] = pins_sync[1];
    end
    if (cfg_reg[BIT_PIN_ZERO_INPUT_EN])
    begin
      cfg_readback[BIT_PIN_ZERO_VALUE] = pins_sync[0];
    end
    if (err_mode == ERR_INPUT)
    begin
      cfg_readback[BIT_ERR_PIN_LEVEL] = sync_level;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= '0;
    end
    else if (setup_phase && !pwrite)
    begin
      case (reg_index(paddr))
        IDX_PIN_CONFIG: prdata <= DATA_W'(cfg_readback);
        IDX_IRQ_STATUS: prdata <= DATA_W'(irq_status_reg);
        IDX_IRQ_ENABLE: prdata <= DATA_W'(irq_enable_reg);
        IDX_AUX_CTRL: prdata <= DATA_W'(alternate_sync_reg);
        default: prdata <= '0;
      endcase
    end
    else
    begin
      prdata <= '0;
    end
  end

  // Configuration registers; reserved bits are masked off on write.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_reg <= PIN_CONFIG_RESET;
      alternate_sync_reg <= 1'b0;
      irq_enable_reg <= '0;
    end
    else if (write_access)
    begin
      if (reg_index(paddr) == IDX_PIN_CONFIG)
      begin
        cfg_reg <= pwdata[CFG_W-1:0] & PIN_CONFIG_WMASK;
      end
      if (reg_index(paddr) == IDX_AUX_CTRL)
      begin
        alternate_sync_reg <= pwdata[BIT_ALTERNATE_SYNC];
      end
      if (reg_index(paddr) == IDX_IRQ_ENABLE)
      begin
        irq_enable_reg <= pwdata[EV_W-1:0];
      end
    end
  end

  // Alternate sync: a low pin at a channel switch holds off the next conversion.
  always_comb
  begin
    sync_state_next = sync_state_reg;
    case (sync_state_reg)
      ST_RUN:
      begin
        if (sync_enabled && alt_effective && chan_switch_due && !sync_level)
        begin
          sync_state_next = ST_STALL;
        end
      end
      ST_STALL:
      begin
        if (sync_level || !sync_enabled || !alt_effective)
        begin
          sync_state_next = ST_RUN;
        end
      end
      default: sync_state_next = ST_RUN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_state_reg <= ST_RUN;
      sync_prev_reg <= 1'b1;
      converter_hold <= 1'b0;
      conversion_stall <= 1'b0;
    end
    else
    begin
      sync_state_reg <= sync_state_next;
      sync_prev_reg <= sync_level;
      converter_hold <= sync_enabled && !alt_effective && !sync_level;
      conversion_stall <= sync_state_next == ST_STALL;
    end
  end

  // Error flag and automatic sequence length.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      adc_error <= 1'b0;
      seq_channels <= '0;
    end
    else
    begin
      adc_error <= (|err_sources) || (err_mode == ERR_INPUT && !sync_level);
      if (chan_enabled_count > CHAN_CNT_W'(MAX_AUTO_SEQ))
      begin
        seq_channels <= 3'(MAX_AUTO_SEQ);
      end
      else
      begin
        seq_channels <= chan_enabled_count[2:0];
      end
    end
  end

  // General-purpose pin drivers; mux drive overrides the per-pin settings.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gp_pin_zero_out <= 1'b0;
      gp_pin_zero_oe <= 1'b0;
      gp_pin_one_out <= 1'b0;
      gp_pin_one_oe <= 1'b0;
    end
    else if (cfg_reg[BIT_EXT_MUX_DRIVE])
    begin
      gp_pin_zero_out <= chan_slot[0];
      gp_pin_zero_oe <= 1'b1;
      gp_pin_one_out <= chan_slot[1];
      gp_pin_one_oe <= 1'b1;
    end
    else
    begin
      gp_pin_zero_out <= cfg_reg[BIT_PIN_ZERO_VALUE];
      gp_pin_zero_oe <= cfg_reg[BIT_PIN_ZERO_OUTPUT_EN];
      gp_pin_one_out <= cfg_reg[BIT_PIN_ONE_VALUE];
      gp_pin_one_oe <= cfg_reg[BIT_PIN_ONE_OUTPUT_EN];
    end
  end

  // An input-only pin keeps its driver off unless mux drive is set, so the readback sees the outside level.
  // is served by the readback path above together with the driver enables here.

  // Sync/error pin driver.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_err_out <= 1'b0;
      sync_err_oe <= 1'b0;
    end
    else
    begin
      case (err_mode)
        ERR_OPEN_DRAIN:
        begin
          sync_err_out <= 1'b0;
          sync_err_oe <= |err_sources;
        end
        ERR_GP_OUTPUT:
        begin
          sync_err_out <= cfg_reg[BIT_ERR_PIN_LEVEL];
          sync_err_oe <= 1'b1;
        end
        default:
        begin
          sync_err_out <= 1'b0;
          sync_err_oe <= 1'b0;
        end
      endcase
    end
  end

  // Interrupts: a new event outranks a clear in the same cycle.
  always_comb
  begin
    irq_events = '0;
    irq_events[EV_SYNC_LOW] = sync_enabled && sync_prev_reg && !sync_level;
    irq_events[EV_ERR_IN] = (err_mode == ERR_INPUT) && sync_prev_reg && !sync_level;
    irq_events[EV_STALL] = (sync_state_reg == ST_RUN) && (sync_state_next == ST_STALL);
    irq_clear = '0;
    if (write_access && reg_index(paddr) == IDX_IRQ_CLEAR)
    begin
      irq_clear = pwdata[EV_W-1:0];
    end
    irq_status_next = (irq_status_reg & ~irq_clear) | irq_events;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_status_reg <= '0;
      irq <= 1'b0;
    end
    else
    begin
      irq_status_reg <= irq_status_next;
      irq <= |(irq_status_next & irq_enable_reg);
    end
  end

  sequence s_switch_while_low;
    sync_enabled && alt_effective && chan_switch_due && !sync_level && !conversion_stall;
  endsequence

  sequence s_pin_released;
    conversion_stall && sync_level;
  endsequence

  property p_mux_drive;
    @(posedge pclk) disable iff (!presetn)
    cfg_reg[BIT_EXT_MUX_DRIVE] |=> gp_pin_zero_oe && gp_pin_one_oe &&
      gp_pin_zero_out == $past(chan_slot[0]) && gp_pin_one_out == $past(chan_slot[1]);
  endproperty
  a_mux_drive: assert property (p_mux_drive) else $error("mux select pins wrong");

  property p_seq_limit;
    @(posedge pclk) disable iff (!presetn)
    seq_channels <= 3'(MAX_AUTO_SEQ);
  endproperty
  a_seq_limit: assert property (p_seq_limit) else $error("sequence length above four");

  property p_sync_hold;
    @(posedge pclk) disable iff (!presetn)
    (sync_enabled && !alt_effective && !sync_level) |=> converter_hold;
  endproperty
  a_sync_hold: assert property (p_sync_hold) else $error("sync low did not hold");

  property p_alt_stall;
    @(posedge pclk) disable iff (!presetn)
    s_switch_while_low |=> conversion_stall && !converter_hold;
  endproperty
  a_alt_stall: assert property (p_alt_stall) else $error("alternate sync did not stall");

  property p_alt_release;
    @(posedge pclk) disable iff (!presetn)
    s_pin_released |=> !conversion_stall;
  endproperty
  a_alt_release: assert property (p_alt_release) else $error("stall not released");

  property p_single_channel;
    @(posedge pclk) disable iff (!presetn)
    (chan_enabled_count <= CHAN_CNT_W'(1)) |=> !conversion_stall;
  endproperty
  a_single_channel: assert property (p_single_channel) else $error("stall with one channel");

  property p_err_off;
    @(posedge pclk) disable iff (!presetn)
    (err_mode == ERR_OFF) |=> !sync_err_oe;
  endproperty
  a_err_off: assert property (p_err_off) else $error("error pin driven while off");

  property p_err_input;
    @(posedge pclk) disable iff (!presetn)
    (err_mode == ERR_INPUT) |=> adc_error == ($past(|err_sources) || !$past(sync_level));
  endproperty
  a_err_input: assert property (p_err_input) else $error("error input not merged");

  property p_open_drain;
    @(posedge pclk) disable iff (!presetn)
    (err_mode == ERR_OPEN_DRAIN) |=> !sync_err_out && sync_err_oe == $past(|err_sources);
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open-drain error wrong");

  property p_gp_output;
    @(posedge pclk) disable iff (!presetn)
    (err_mode == ERR_GP_OUTPUT) |=> sync_err_oe && sync_err_out == $past(cfg_reg[BIT_ERR_PIN_LEVEL]);
  endproperty
  a_gp_output: assert property (p_gp_output) else $error("error pin output level wrong");

  property p_sticky_set_wins;
    @(posedge pclk) disable iff (!presetn)
    (irq_events[EV_SYNC_LOW] && irq_clear[EV_SYNC_LOW]) |=> irq_status_reg[EV_SYNC_LOW];
  endproperty
  a_sticky_set_wins: assert property (p_sticky_set_wins) else $error("event lost to clear");

endmodule
`default_nettype wire

// File: src/_unused_marker_removed.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// File: verif/pin_partner.sv
// Far-side model: peer pin sources, wired-OR error line with pull-up, external mux.
// Assumes the bench sets the peer levels and never fights a push-pull driver.
`timescale 1ns/1ps
`default_nettype none

module pin_partner
(
  // Design pin drivers
  input wire logic [2:0] d_out,
  input wire logic [2:0] d_oe,
  // Peer sources
  input wire logic [1:0] peer_gp,
  input wire logic peer_low,
  // Resolved levels
  output logic [2:0] level,
  output logic [1:0] mux_sel
);
  // A released general pin is driven by the peer source.
  assign level[0] = d_oe[0] ? d_out[0] : peer_gp[0];
  assign level[1] = d_oe[1] ? d_out[1] : peer_gp[1];
  // The pull-up wins only while no device sinks the shared line.
  assign level[2] = (d_oe[2] ? d_out[2] : 1'b1) & ~peer_low;
  assign mux_sel = (d_oe[1:0] == 2'b11) ? level[1:0] : 2'b00;
endmodule

`default_nettype wire

// File: verif/tb.sv
// Bench for the pin controller: APB master, reference model, random pin traffic.
// Assumes the far-side model resolves pin levels and the external mux select.
`timescale 1ns/1ps
`default_nettype none

module tb;
  import gpio_pin_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic pready, pslverr, rerr, due;
  logic [1:0] slot, peer_gp, mux_sel;
  logic [3:0] cnt, err_src;
  logic hold, stall, adc_error, irq, peer_low;
  logic [2:0] seqc;
  logic [15:0] cfg_m;
  wire logic [2:0] d_out, d_oe, level;
  int n_errors = 0;
  int n_checks = 0;

  always #2 pclk = ~pclk;

  gpio_sync_error_pin_control i_gpio_sync_error_pin_control (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .chan_slot(slot), .chan_switch_due(due), .chan_enabled_count(cnt),
    .err_sources(err_src), .converter_hold(hold), .conversion_stall(stall), .adc_error,
    .seq_channels(seqc), .irq, .gp_pin_zero_in(level[0]), .gp_pin_zero_out(d_out[0]),
    .gp_pin_zero_oe(d_oe[0]), .gp_pin_one_in(level[1]), .gp_pin_one_out(d_out[1]),
    .gp_pin_one_oe(d_oe[1]), .sync_err_in(level[2]), .sync_err_out(d_out[2]),
    .sync_err_oe(d_oe[2]));

  pin_partner i_pin_partner (.d_out, .d_oe, .peer_gp, .peer_low, .level, .mux_sel);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 16);
    // Read right after the edge, before the design's updates land: the sampled answer.
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 16)
    begin
      chk(0, 1, "apb hang");
      give_verdict();
    end
  endtask

  // Pin levels pass two sync flops and a registered output stage.
  task automatic settle;
    repeat (5) @(posedge pclk);
  endtask

  function automatic logic [15:0] cfg_read(input logic [15:0] c, input logic [2:0] lv);
    logic [15:0] v;
    v = c;
    if (c[5]) v[1] = lv[1];
    if (c[4]) v[0] = lv[0];
    if (c[10:9] == 2'b01) v[8] = lv[2];
    return v;
  endfunction

  task automatic check_pins;
    logic [2:0] oe, o;
    int lim;
    oe = cfg_m[12] ? 3'b011 : {1'b0, cfg_m[3], cfg_m[2]};
    o = cfg_m[12] ? {1'b0, slot} : {1'b0, cfg_m[1:0]};
    case (cfg_m[10:9])
      2'b10: oe[2] = |err_src;
      2'b11: {oe[2], o[2]} = {1'b1, cfg_m[8]};
      default: ;
    endcase
    lim = (cnt > 4) ? 4 : cnt;
    chk(d_oe, oe, "pin enables");
    chk(d_out & oe, o & oe, "pin levels");
    chk(seqc, lim, "seq channels");
    chk(adc_error, |err_src | (cfg_m[10:9] == 2'b01 & ~level[2]), "fault");
    chk(hold, cfg_m[11] & ~level[2], "hold");
    if (cfg_m[12]) chk(mux_sel, slot, "mux select");
    apb(8'h18, 1'b0, 0);
    chk(rdat, cfg_read(cfg_m, level), "config read");
  endtask

  initial
  begin
    #200000;
    chk(0, 1, "watchdog");
    give_verdict();
  end

  initial
  begin
    int r;
    paddr = 8'h00;
    pwdata = 32'h0;
    slot = 2'b00;
    due = 1'b0;
    cnt = 4'h2;
    err_src = 4'h0;
    peer_gp = 2'b00;
    peer_low = 1'b0;
    cfg_m = 16'h0800;
    r = $urandom(32'h7dd231bd);
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    check_pins();
    apb(8'h1c, 1'b0, 0);
    chk(rerr, 1'b1, "unmapped read");
    for (int i = 0; i < 40; i++)
    begin
      r = $urandom;
      apb(8'h18, 1'b1, r);
      cfg_m = r[15:0] & 16'h1f3f;
      slot <= r[17:16];
      peer_gp <= r[19:18];
      err_src <= r[23:20];
      cnt <= r[27:24];
      peer_low <= r[28] & (r[10:9] != 2'b11);
      settle();
      check_pins();
    end
    apb(8'h18, 1'b1, 32'h0800);
    cfg_m = 16'h0800;
    apb(8'h2c, 1'b1, 32'h1);
    cnt <= 4'h3;
    err_src <= 4'h0;
    peer_low <= 1'b1;
    settle();
    chk({hold, stall}, 2'b00, "alt no hold");
    due <= 1'b1;
    @(posedge pclk);
    due <= 1'b0;
    settle();
    chk(stall, 1'b1, "stall on switch");
    peer_low <= 1'b0;
    settle();
    chk(stall, 1'b0, "stall released");
    cnt <= 4'h1;
    peer_low <= 1'b1;
    settle();
    chk(hold, 1'b1, "single channel hold");
    peer_low <= 1'b0;
    apb(8'h2c, 1'b1, 32'h0);
    apb(8'h24, 1'b1, 32'h7);
    apb(8'h28, 1'b1, 32'h1);
    settle();
    chk(irq, 1'b0, "irq idle");
    peer_low <= 1'b1;
    settle();
    chk(irq, 1'b1, "irq raised");
    apb(8'h20, 1'b0, 0);
    chk(rdat[0], 1'b1, "sync event");
    apb(8'h28, 1'b1, 32'h0);
    settle();
    chk(irq, 1'b0, "irq masked");
    apb(8'h28, 1'b1, 32'h1);
    settle();
    chk(irq, 1'b1, "irq unmasked");
    apb(8'h24, 1'b1, 32'h1);
    settle();
    chk(irq, 1'b0, "irq cleared");
    give_verdict();
  end
endmodule

`default_nettype wire
